// ==== smim_consts.svh ====
// Constants of the serial management slave with indirect extended access
// What this block does
// - Data bits sampled on management clock rise.
// - Data line idles high, nobody drives idle.
// - Answer only frames matching own address.
// - Capture two strap bits as bus address.
// - Direct access selects one of 32 registers.
// - Frame starts with pattern 01 after idle.
// - Nobody drives first read turnaround bit.
// - Read drives zero, then sixteen data bits.
// - Standard registers reachable directly and indirectly.
// - Indirect access to control/data registers ignored.
// - Only device addresses 31, 3, 7 honoured.
// - Function field selects address or data mode.
// - Function 00 reaches the extended address register.
// - Function 01 accesses data, pointer unchanged.
// - Function 10 increments after reads and writes.
// - Function 11 increments after writes only.
`ifndef SMIM_CONSTS_SVH
`define SMIM_CONSTS_SVH

`define SMIM_REG_CTRL      5'h0D
`define SMIM_REG_ADDAT     5'h0E
`define SMIM_DEV_VEND      5'h1F
`define SMIM_DEV_PCS       5'h03
`define SMIM_DEV_AN        5'h07
`define SMIM_FN_ADDR       2'h0
`define SMIM_FN_DATA       2'h1
`define SMIM_FN_INC_RW     2'h2
`define SMIM_FN_INC_W      2'h3
`define SMIM_FN_HI         15
`define SMIM_FN_LO         14
`define SMIM_DEV_HI        4
`define SMIM_OP_RD         2'h2
`define SMIM_OP_WR         2'h1
`define SMIM_CTRL_RST      16'h0000
`define SMIM_EXTADDR_RST   16'h0000
`define SMIM_REG_RST       16'h0000
`define SMIM_HDR_LAST      5'h0B
`define SMIM_DATA_LAST     5'h0F
`define SMIM_SKIP_LAST     5'h11
`define SMIM_TA_SKIP_START 5'h02
`define SMIM_EXT_IDX_W     8

`endif

// ==== smim_pkg.sv ====
// Types of the serial management slave
package smim_pkg;
    typedef enum logic [2:0] {
        SMIM_IDLE  = 3'b000,
        SMIM_START = 3'b001,
        SMIM_HDR   = 3'b010,
        SMIM_TA    = 3'b011,
        SMIM_DATA  = 3'b100,
        SMIM_SKIP  = 3'b101
    } smim_state_type;
endpackage

// ==== smim_slave.sv ====
// Management frame slave with direct and indirect register access
`timescale 1ns/1ns
`include "smim_consts.svh"
module smim_slave
    import smim_pkg::*;
(
    input  wire logic       sys_clk,     // System clock, 100 MHz
    input  wire logic       rst_n,       // Async reset, active low
    input  wire logic       mdc,         // Management clock pin
    input  wire logic       mdio_in,     // Management data pin level
    output logic            mdio_out,    // Management data drive value
    output logic            mdio_oe,     // High while driving data pin
    input  wire logic [1:0] addr_strap,  // Address strap pins
    output logic      [1:0] bus_addr     // Latched bus address
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge finding

    logic [2:0]     mdc_s_r;
    logic [2:0]     mdio_s_r;
    logic           mdc_lvl_r;
    logic           mdio_lvl_r;
    logic           mdc_agree;
    logic           mdio_agree;
    logic           mdc_rise;
    logic           bit_in;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_s_r    <= 3'h7;
            mdio_s_r   <= 3'h7;
            mdc_lvl_r  <= 1'b1;
            mdio_lvl_r <= 1'b1;
        end else begin
            mdc_s_r  <= {mdc_s_r[1:0], mdc};
            mdio_s_r <= {mdio_s_r[1:0], mdio_in};
            if (mdc_agree)
                mdc_lvl_r <= mdc_s_r[2];
            if (mdio_agree)
                mdio_lvl_r <= mdio_s_r[2];
        end
    end

    assign mdc_agree  = mdc_s_r[1] == mdc_s_r[2];
    assign mdio_agree = mdio_s_r[1] == mdio_s_r[2];
    // A stopped clock gives no edges, so the frame simply waits
    assign mdc_rise   = mdc_agree && mdc_s_r[2] && !mdc_lvl_r;
    assign bit_in     = mdio_agree ? mdio_s_r[2] : mdio_lvl_r;

    ////////////////////////////////////////////////////////////////////
    // Strap capture

    logic [1:0]     my_addr_r;
    logic           strap_done_r;
    logic [1:0]     strap_s1_r;
    logic [1:0]     strap_s2_r;
    logic [1:0]     strap_s3_r;
    logic [1:0]     strap_fill_r;
    logic           strap_agree;

    // Straps are static, yet still pass the same three stages as any pin
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_r   <= 2'h0;
            strap_s2_r   <= 2'h0;
            strap_s3_r   <= 2'h0;
            strap_fill_r <= 2'h0;
        end else begin
            strap_s1_r <= addr_strap;
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
            if (strap_fill_r != 2'h3)
                strap_fill_r <= strap_fill_r + 2'h1;
        end
    end

    // Only samples taken after release count, never a reset value
    assign strap_agree = strap_fill_r == 2'h3 && strap_s2_r == strap_s3_r;

    // Caught once after release, then frozen until the next reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            my_addr_r    <= 2'h0;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r && strap_agree) begin
            my_addr_r    <= strap_s3_r;
            strap_done_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register storage and decode

    logic [15:0]    regs_r [0:31];
    logic [15:0]    ext_mem [0:255];
    logic [15:0]    ctrl_r;
    logic [15:0]    ext_addr_r;
    logic [1:0]     func;
    logic [4:0]     devad;
    logic           devad_ok;
    logic [1:0]     mmd_sel;
    logic [`SMIM_EXT_IDX_W-1:0] ext_idx;
    logic           ext_std;
    logic           ext_blocked;
    logic           data_fn;

    assign func     = ctrl_r[`SMIM_FN_HI:`SMIM_FN_LO];
    assign devad    = ctrl_r[`SMIM_DEV_HI:0];
    assign devad_ok = devad == `SMIM_DEV_VEND
                   || devad == `SMIM_DEV_PCS
                   || devad == `SMIM_DEV_AN;
    assign mmd_sel  = (devad == `SMIM_DEV_VEND) ? 2'h0 :
                      (devad == `SMIM_DEV_PCS)  ? 2'h1 : 2'h2;
    // Only the low six pointer bits index the extended store
    assign ext_idx  = {mmd_sel, ext_addr_r[5:0]};
    assign ext_std  = devad == `SMIM_DEV_VEND
                   && ext_addr_r[15:5] == 11'h000;
    assign ext_blocked = ext_std
                   && (ext_addr_r[4:0] == `SMIM_REG_CTRL
                    || ext_addr_r[4:0] == `SMIM_REG_ADDAT);
    assign data_fn  = func != `SMIM_FN_ADDR;

    ////////////////////////////////////////////////////////////////////
    // Frame state

    smim_state_type st_r;
    logic [4:0]     cnt_r;
    logic [11:0]    hdr_r;
    logic [11:0]    hdr_full;
    logic [4:0]     reg_r;
    logic           rd_r;
    logic [15:0]    rd_data_r;
    logic [15:0]    wd_r;
    logic [15:0]    wdata;
    logic           out_r;
    logic           oe_r;
    logic [1:0]     h_op;
    logic [4:0]     h_phy;
    logic [4:0]     h_reg;
    logic           h_op_ok;
    logic           h_match;
    logic [15:0]    rd_value;
    logic           hdr_end;
    logic           fin;

    assign hdr_full = {hdr_r[10:0], bit_in};
    assign h_op     = hdr_full[11:10];
    assign h_phy    = hdr_full[9:5];
    assign h_reg    = hdr_full[4:0];
    assign h_op_ok  = h_op == `SMIM_OP_RD || h_op == `SMIM_OP_WR;
    assign h_match  = h_phy == {3'h0, my_addr_r};
    assign hdr_end  = mdc_rise && st_r == SMIM_HDR
                   && cnt_r == `SMIM_HDR_LAST;
    assign fin      = mdc_rise && st_r == SMIM_DATA
                   && cnt_r == `SMIM_DATA_LAST;
    assign wdata    = {wd_r[14:0], bit_in};

    // Read value is frozen at header end, before turnaround
    assign rd_value =
        (h_reg == `SMIM_REG_CTRL)  ? ctrl_r :
        (h_reg != `SMIM_REG_ADDAT) ? regs_r[h_reg] :
        !devad_ok                  ? 16'h0000 :
        !data_fn                   ? ext_addr_r :
        ext_blocked                ? 16'h0000 :
        ext_std                    ? regs_r[ext_addr_r[4:0]] :
                                     ext_mem[ext_idx];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r      <= SMIM_IDLE;
            cnt_r     <= 5'h00;
            hdr_r     <= 12'h000;
            reg_r     <= 5'h00;
            rd_r      <= 1'b0;
            rd_data_r <= 16'h0000;
            wd_r      <= 16'h0000;
            out_r     <= 1'b1;
            oe_r      <= 1'b0;
        end else if (mdc_rise) begin
            unique case (st_r)
                SMIM_IDLE: begin
                    if (!bit_in)
                        st_r <= SMIM_START;
                end
                SMIM_START: begin
                    cnt_r <= 5'h00;
                    st_r  <= bit_in ? SMIM_HDR : SMIM_IDLE;
                end
                SMIM_HDR: begin
                    hdr_r <= hdr_full;
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == `SMIM_HDR_LAST) begin
                        cnt_r     <= 5'h00;
                        reg_r     <= h_reg;
                        rd_r      <= h_op == `SMIM_OP_RD;
                        rd_data_r <= rd_value;
                        st_r <= (h_op_ok && h_match) ? SMIM_TA
                                                     : SMIM_SKIP;
                    end
                end
                SMIM_TA: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == 5'h00) begin
                        if (rd_r) begin
                            oe_r  <= 1'b1;
                            out_r <= 1'b0;
                        end else if (!bit_in) begin
                            st_r <= SMIM_SKIP;
                        end
                    end else begin
                        cnt_r <= 5'h00;
                        st_r  <= SMIM_DATA;
                        if (rd_r) begin
                            out_r     <= rd_data_r[15];
                            rd_data_r <= {rd_data_r[14:0], 1'b0};
                        end else if (bit_in) begin
                            cnt_r <= `SMIM_TA_SKIP_START;
                            st_r  <= SMIM_SKIP;
                        end
                    end
                end
                SMIM_DATA: begin
                    cnt_r     <= cnt_r + 5'h01;
                    wd_r      <= wdata;
                    out_r     <= rd_data_r[15];
                    rd_data_r <= {rd_data_r[14:0], 1'b0};
                    if (cnt_r == `SMIM_DATA_LAST) begin
                        oe_r  <= 1'b0;
                        out_r <= 1'b1;
                        st_r  <= SMIM_IDLE;
                    end
                end
                SMIM_SKIP: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == `SMIM_SKIP_LAST)
                        st_r <= SMIM_IDLE;
                end
                default: begin
                    st_r <= SMIM_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Commit of writes and pointer updates

    logic           wr_fin;
    logic           ad_fin;
    logic           ptr_wr;
    logic           ptr_inc;
    logic           dir_wr;
    logic [4:0]     dir_idx;
    logic           ext_wr;

    assign wr_fin  = fin && !rd_r;
    assign ad_fin  = fin && reg_r == `SMIM_REG_ADDAT && devad_ok;
    assign ptr_wr  = ad_fin && !rd_r && !data_fn;
    assign ptr_inc = ad_fin && (func == `SMIM_FN_INC_RW
                 || (func == `SMIM_FN_INC_W && !rd_r));
    assign dir_wr  = wr_fin && ((reg_r != `SMIM_REG_CTRL
                              && reg_r != `SMIM_REG_ADDAT)
                             || (ad_fin && data_fn && ext_std
                              && !ext_blocked));
    assign dir_idx = (reg_r == `SMIM_REG_ADDAT) ? ext_addr_r[4:0] : reg_r;
    assign ext_wr  = ad_fin && !rd_r && data_fn && !ext_std;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r     <= `SMIM_CTRL_RST;
            ext_addr_r <= `SMIM_EXTADDR_RST;
        end else begin
            if (wr_fin && reg_r == `SMIM_REG_CTRL)
                ctrl_r <= wdata;
            if (ptr_wr)
                ext_addr_r <= wdata;
            else if (ptr_inc)
                ext_addr_r <= ext_addr_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++)
                regs_r[i] <= `SMIM_REG_RST;
        end else if (dir_wr) begin
            regs_r[dir_idx] <= wdata;
        end
    end

    // Extended store has no reset, like a register file macro
    always_ff @(posedge sys_clk) begin
        if (ext_wr)
            ext_mem[ext_idx] <= wdata;
    end

    assign mdio_out = out_r;
    assign mdio_oe  = oe_r;
    assign bus_addr = my_addr_r;

    ////////////////////////////////////////////////////////////////////
    // Checks

    chk_ta_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(oe_r) |-> !out_r && rd_r && st_r == SMIM_TA)
        else $error("Read turnaround did not drive zero");

    chk_ta_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
        hdr_end |=> !oe_r)
        else $error("Data line driven in first turnaround bit");

    chk_write_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (st_r == SMIM_SKIP || (st_r == SMIM_DATA && !rd_r)) |-> !oe_r)
        else $error("Data line driven outside own read");

    chk_addr_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(oe_r) |-> hdr_r[9:5] == {3'h0, my_addr_r})
        else $error("Answered a frame for another address");

    chk_strap_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strap_done_r && $past(strap_done_r) |-> $stable(my_addr_r))
        else $error("Bus address changed after capture");

    chk_inc_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ad_fin && func == `SMIM_FN_INC_RW)
        |=> ext_addr_r == $past(ext_addr_r) + 16'h0001)
        else $error("Pointer not incremented");

    chk_no_inc_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ad_fin && rd_r && func == `SMIM_FN_INC_W) |=> $stable(ext_addr_r))
        else $error("Pointer moved on read in write-increment mode");

    chk_bad_devad: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fin && reg_r == `SMIM_REG_ADDAT && !devad_ok)
        |=> $stable(ext_addr_r))
        else $error("Ignored device address changed pointer");

    chk_plain_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ad_fin && func == `SMIM_FN_DATA) |=> $stable(ext_addr_r))
        else $error("Pointer moved in plain data mode");

    chk_oe_ends: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fin |=> !oe_r && out_r && st_r == SMIM_IDLE)
        else $error("Data line not released after frame");

    chk_ptr_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ptr_wr |=> ext_addr_r == $past(wdata))
        else $error("Pointer not loaded by address function write");

    chk_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_fin && reg_r == `SMIM_REG_CTRL) |=> ctrl_r == $past(wdata))
        else $error("Access control register not written");

endmodule

// ==== smim_station.sv ====
// Station model driving the management clock and data wire
`timescale 1ns/1ns
module smim_station (
    output logic      mdc,       // Management clock, stopped between frames
    output logic      drv_oe,    // High while the station drives the wire
    output logic      drv_val,   // Station drive value
    input  wire logic mdio_wire  // Resolved wire level
);
    localparam int HALF_LO = 63;
    localparam int HALF_HI = 62;
    initial begin
        mdc = 1'b0;
        drv_oe = 1'b0;
        drv_val = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // Drive while low, sample at the rise; 8 MHz is well below the limit
    task automatic bit_cyc(input logic oe, input logic val, output logic smp);
        drv_oe = oe;
        drv_val = oe ? val : 1'b0;
        #HALF_LO;
        mdc = 1'b1;
        smp = mdio_wire;
        #HALF_HI;
        mdc = 1'b0;
    endtask
    // Returns {second turnaround bit, data} on reads
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] rg, input logic [1:0] ta,
                         input logic [15:0] wd, output logic [16:0] rd);
        logic [31:0] bits;
        logic        rdop;
        logic        smp;
        bits = {2'b01, op, phy, rg, ta, wd};
        rdop = (op == 2'b10);
        rd = '0;
        bit_cyc(1'b1, 1'b1, smp);
        for (int i = 31; i >= 0; i--) begin
            bit_cyc(!(rdop && i < 18), bits[i], smp);
            if (i < 17) rd = {rd[15:0], smp};
        end
        // Clock stays low until the next frame
        drv_oe = 1'b0;
    endtask
endmodule

// ==== tb_smi_mgmt_with_mmd_indirect.sv ====
// Testbench of the management frame slave
`timescale 1ns/1ns
module tb_smi_mgmt_with_mmd_indirect;
    localparam logic [1:0] STRAP = 2'b10;
    localparam logic [4:0] PHY   = {3'b000, STRAP};
    logic       sys_clk;
    logic       rst_n;
    logic       mdc;
    logic       st_oe;
    logic       st_val;
    logic       mdio_out;
    logic       mdio_oe;
    logic       foreign;
    logic [1:0] addr_strap;
    logic [1:0] bus_addr;
    logic [16:0] rd;
    int         num_errors;
    int         cmp_count;
    // Pull-up holds the wire when nobody drives it
    wire mdio_wire = mdio_oe ? mdio_out : (st_oe ? st_val : 1'b1);

    smim_slave i_smim_slave (.sys_clk(sys_clk), .rst_n(rst_n), .mdc(mdc),
        .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .addr_strap(addr_strap), .bus_addr(bus_addr));
    smim_station i_smim_station (.mdc(mdc), .drv_oe(st_oe),
        .drv_val(st_val), .mdio_wire(mdio_wire));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] rg, input logic [15:0] d);
        i_smim_station.frame(2'b01, PHY, rg, 2'b10, d, rd);
    endtask
    task automatic rdchk(input logic [4:0] rg, input logic [15:0] exp);
        i_smim_station.frame(2'b10, PHY, rg, 2'b11, 16'h0000, rd);
        chk(rd, {1'b0, exp});
    endtask
    // Device must never drive against the station or on foreign frames
    always @(negedge sys_clk) begin
        if (mdio_oe === 1'b1 && (st_oe === 1'b1 || foreign)) chk(1, 0);
    end
    ////////////////////////////////////////////////////////////
    task automatic t_direct();
        chk(bus_addr, STRAP);
        addr_strap = 2'b01;
        rdchk(5'h0D, 16'h0000);
        wr(5'h00, 16'hA5C3);
        // Clock stands still while the bus is idle
        repeat (40) @(negedge sys_clk);
        wr(5'h1F, 16'h3C5A);
        rdchk(5'h00, 16'hA5C3);
        rdchk(5'h1F, 16'h3C5A);
        chk(mdio_oe, 1'b0);
        chk(bus_addr, STRAP);
    endtask
    task automatic t_refuse();
        foreign = 1'b1;
        i_smim_station.frame(2'b01, PHY ^ 5'h01, 5'h00, 2'b10, 16'h1234, rd);
        i_smim_station.frame(2'b10, PHY ^ 5'h01, 5'h00, 2'b11, 16'h0000, rd);
        chk(rd, 17'h1_FFFF);
        i_smim_station.frame(2'b01, PHY, 5'h00, 2'b11, 16'h0BAD, rd);
        i_smim_station.frame(2'b00, PHY, 5'h00, 2'b10, 16'h0BAD, rd);
        foreign = 1'b0;
        rdchk(5'h00, 16'hA5C3);
    endtask
    task automatic t_ptr();
        wr(5'h0D, 16'h001F);
        wr(5'h0E, 16'h0461);
        rdchk(5'h0E, 16'h0461);
        wr(5'h0D, 16'h401F);
        wr(5'h0E, 16'h0400);
        rdchk(5'h0E, 16'h0400);
        rdchk(5'h0E, 16'h0400);
        wr(5'h0D, 16'h001F);
        rdchk(5'h0E, 16'h0461);
    endtask
    task automatic t_inc();
        wr(5'h0D, 16'h001F);
        wr(5'h0E, 16'h0100);
        wr(5'h0D, 16'h801F);
        wr(5'h0E, 16'h1111);
        wr(5'h0E, 16'h2222);
        wr(5'h0D, 16'h001F);
        rdchk(5'h0E, 16'h0102);
        wr(5'h0E, 16'h0100);
        wr(5'h0D, 16'h801F);
        rdchk(5'h0E, 16'h1111);
        rdchk(5'h0E, 16'h2222);
        wr(5'h0D, 16'h001F);
        rdchk(5'h0E, 16'h0102);
        wr(5'h0E, 16'h0100);
        wr(5'h0D, 16'hC01F);
        rdchk(5'h0E, 16'h1111);
        rdchk(5'h0E, 16'h1111);
        wr(5'h0E, 16'h3333);
        rdchk(5'h0E, 16'h2222);
        wr(5'h0D, 16'h001F);
        rdchk(5'h0E, 16'h0101);
        wr(5'h0E, 16'h0100);
        wr(5'h0D, 16'h401F);
        rdchk(5'h0E, 16'h3333);
    endtask
    task automatic t_mmd();
        wr(5'h0D, 16'h001F);
        wr(5'h0E, 16'h000D);
        wr(5'h0D, 16'h401F);
        wr(5'h0E, 16'hFFFF);
        rdchk(5'h0E, 16'h0000);
        rdchk(5'h0D, 16'h401F);
        wr(5'h0D, 16'h001F);
        wr(5'h0E, 16'h0010);
        wr(5'h0D, 16'h401F);
        wr(5'h0E, 16'h7777);
        rdchk(5'h10, 16'h7777);
        wr(5'h0D, 16'h4003);
        wr(5'h0E, 16'hAAAA);
        wr(5'h0D, 16'h4007);
        wr(5'h0E, 16'h5555);
        wr(5'h0D, 16'h4005);
        wr(5'h0E, 16'h1234);
        rdchk(5'h0E, 16'h0000);
        wr(5'h0D, 16'h4003);
        rdchk(5'h0E, 16'hAAAA);
        wr(5'h0D, 16'h4007);
        rdchk(5'h0E, 16'h5555);
        chk(mdio_oe, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        cmp_count = 0;
        foreign = 1'b0;
        rst_n = 1'b0;
        addr_strap = STRAP;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        // Bus stays quiet for well over one management clock
        repeat (30) @(negedge sys_clk);
        t_direct();
        t_refuse();
        t_ptr();
        t_inc();
        t_mmd();
        end_sim();
    end
    initial begin
        #900000;
        num_errors++;
        end_sim();
    end
endmodule
